// >>> xmw_pkg.sv
// Package of constants, opcodes and phase encodings for the multi-line write command front end.
package xmw_pkg;

    // Recognised write opcodes.
    localparam logic [7:0] OPC_DOUBLE_EDGE_WRITE             = 8'hdd;
    localparam logic [7:0] OPC_TWO_LINE_DATA_WRITE           = 8'ha2;
    localparam logic [7:0] OPC_TWO_LINE_ADDR_DATA_WRITE      = 8'ha1;
    localparam logic [7:0] OPC_FOUR_LINE_DATA_WRITE          = 8'h32;
    localparam logic [7:0] OPC_FOUR_LINE_ADDR_DATA_WRITE     = 8'hd2;
    localparam logic [7:0] OPC_DOUBLE_EDGE_FOUR_LINE_WRITE   = 8'hd1;

    // Mode byte patterns for entering the opcode-free continuous mode.
    localparam logic [7:0] MODE_EXACT_ENTRY   = 8'ha5;
    localparam logic [3:0] MODE_NIBBLE_ENTRY  = 4'ha;

    // Bit counts of each field.
    localparam logic [5:0] OPCODE_BITS  = 6'h08;
    localparam logic [5:0] ADDRESS_BITS = 6'h18;
    localparam logic [5:0] MODE_BITS    = 6'h08;
    localparam logic [5:0] DATA_BITS    = 6'h08;

    // Top of the 20-bit byte address space, and bit index of the write enable latch.
    localparam logic [19:0] ADDR_TOP      = 20'hfffff;
    localparam logic [19:0] ADDR_RESET    = 20'h00000;
    localparam int          WEL_BIT_INDEX = 1;

    // Synchroniser and buffer reset values.
    localparam logic [7:0] OPCODE_RESET = 8'h00;
    localparam logic [1:0] SYNC_RESET   = 2'h0;

    // Command phases.
    typedef enum logic [2:0] {
        PH_IDLE    = 3'b000,
        PH_OPCODE  = 3'b001,
        PH_ADDRESS = 3'b010,
        PH_MODE    = 3'b011,
        PH_DATA    = 3'b100,
        PH_IGNORE  = 3'b101
    } xmw_phase_e;

endpackage

// >>> xmw_multi_io_write.sv
// Command front end decoding multi-line serial write commands and their continuous mode.
`timescale 1ns/1ps
//
// Functional notes
// - DDR fast write mode byte A5 enters continuous mode.
// - Continuous DDR fast write skips opcode, starts with address.
// - Writes execute only while write enable latch set.
// - Write enable latch stays set after completion.
// - Two-line data write: opcode, address, mode single line.
// - Two-line data write data: two bits, bit7 line1.
// - SDR multi-line mode upper nibble A enters continuous.
// - Continuous mode selection starts directly with address.
// - Non-matching mode byte leaves continuous mode.
// - Two-line address write: address, mode, data two lines.
// - Four-line data write: data four lines, bits 7-4.
// - Four-line address write: all after opcode four lines.
// - DDR four-line write: both edges, mode A5.
// - DDR four-line write other mode byte exits continuous.
// - DDR transfers sample on rising and falling edges.
// - Byte address increments, wraps 0x0FFFFF to zero.
// - Write enable latch is status register one bit 1.
//
module xmw_multi_io_write
    import xmw_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_clk_en,
    input  wire logic        i_cs_n,
    input  wire logic        i_sck,
    input  wire logic [3:0]  i_io,
    input  wire logic [7:0]  i_status_register_one,
    input  wire logic        i_wr_ready,
    output logic             o_wr_valid,
    output logic [19:0]      o_wr_addr,
    output logic [7:0]       o_wr_data,
    output logic             o_continuous_mode,
    output logic [7:0]       o_continuous_opcode,
    output logic             o_rejected,
    output logic             o_overrun
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Lines in use for a given command and phase; the opcode is always one line.
    function automatic logic [2:0] lane_count(input logic [7:0] cmd, input xmw_phase_e ph);
        logic [2:0] n;
        n = 3'h1;
        if (ph != PH_OPCODE) begin
            case (cmd)
                OPC_TWO_LINE_DATA_WRITE:      n = (ph == PH_DATA) ? 3'h2 : 3'h1;
                OPC_TWO_LINE_ADDR_DATA_WRITE: n = 3'h2;
                OPC_FOUR_LINE_DATA_WRITE:     n = (ph == PH_DATA) ? 3'h4 : 3'h1;
                OPC_FOUR_LINE_ADDR_DATA_WRITE,
                OPC_DOUBLE_EDGE_FOUR_LINE_WRITE,
                OPC_DOUBLE_EDGE_WRITE:        n = 3'h4;
                default:                      n = 3'h1;
            endcase
        end
        return n;
    endfunction

    // True for the commands that move address and data on both clock edges.
    function automatic logic is_double_edge(input logic [7:0] cmd);
        return (cmd == OPC_DOUBLE_EDGE_WRITE) || (cmd == OPC_DOUBLE_EDGE_FOUR_LINE_WRITE);
    endfunction

    // True for any opcode handled by this block.
    function automatic logic is_known(input logic [7:0] cmd);
        return is_double_edge(cmd) || (cmd == OPC_TWO_LINE_DATA_WRITE) ||
               (cmd == OPC_TWO_LINE_ADDR_DATA_WRITE) || (cmd == OPC_FOUR_LINE_DATA_WRITE) ||
               (cmd == OPC_FOUR_LINE_ADDR_DATA_WRITE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is read by any logic.

    logic [1:0] cs_sync_q;
    logic [1:0] sck_sync_q;
    logic [3:0] io_meta_q;
    logic [3:0] io_sync_q;
    logic       sck_prev_q;
    logic       cs_prev_q;

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            cs_sync_q  <= 2'h3;
            sck_sync_q <= SYNC_RESET;
            io_meta_q  <= 4'h0;
            io_sync_q  <= 4'h0;
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
        end else if (i_clk_en) begin
            cs_sync_q  <= {cs_sync_q[0], i_cs_n};
            sck_sync_q <= {sck_sync_q[0], i_sck};
            io_meta_q  <= i_io;
            io_sync_q  <= io_meta_q;
            sck_prev_q <= sck_sync_q[1];
            cs_prev_q  <= cs_sync_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge events on the synchronised pins.

    logic cs_low;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;

    assign cs_low   = !cs_sync_q[1];
    assign cs_fall  = cs_prev_q && !cs_sync_q[1];
    assign sck_rise = cs_low && !sck_prev_q && sck_sync_q[1];
    assign sck_fall = cs_low && sck_prev_q && !sck_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Command state.

    xmw_phase_e  phase_q;
    logic [7:0]  cmd_q;
    logic [23:0] shift_q;
    logic [5:0]  count_q;
    logic [19:0] addr_q;
    logic        xip_q;
    logic [7:0]  xip_cmd_q;
    logic        fall_ok_q;

    // Combinational sample step: lanes, sampling edge and the shifted value.
    logic [2:0]  lanes;
    logic        sample;
    logic [23:0] shift_d;
    logic [5:0]  count_d;
    logic [5:0]  field_bits;
    logic        field_done;
    logic        mode_match;
    logic        push;

    always_comb begin
        lanes = lane_count(cmd_q, phase_q);
        // The opcode is always taken on the rising edge; double-edge commands also take
        // the falling edge afterwards. Only clock mode 0 is assumed for them.
        sample = sck_rise ||
                 (sck_fall && fall_ok_q && is_double_edge(cmd_q) && (phase_q != PH_OPCODE));
        // The highest line in use (line 3, 1 or 0) carries the most significant bit of each group.
        case (lanes)
            3'h2:    shift_d = {shift_q[21:0], io_sync_q[1:0]};
            3'h4:    shift_d = {shift_q[19:0], io_sync_q[3:0]};
            default: shift_d = {shift_q[22:0], io_sync_q[0]};
        endcase
        count_d = count_q + {3'h0, lanes};
        case (phase_q)
            PH_OPCODE:  field_bits = OPCODE_BITS;
            PH_ADDRESS: field_bits = ADDRESS_BITS;
            PH_MODE:    field_bits = MODE_BITS;
            default:    field_bits = DATA_BITS;
        endcase
        field_done = sample && (count_d == field_bits);
        if (is_double_edge(cmd_q)) begin
            mode_match = (shift_d[7:0] == MODE_EXACT_ENTRY);
        end else begin
            mode_match = (shift_d[7:4] == MODE_NIBBLE_ENTRY);
        end
        push = field_done && (phase_q == PH_DATA);
    end

    // Double-edge sampling starts at the first rising edge after the opcode. The falling edge
    // that closes the last opcode bit only launches the first address group, so it is skipped.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            fall_ok_q <= 1'b0;
        end else if (i_clk_en) begin
            if (!cs_low || cs_fall) begin
                fall_ok_q <= 1'b0;
            end else if (sck_rise && (phase_q != PH_OPCODE) && (phase_q != PH_IDLE)) begin
                fall_ok_q <= 1'b1;
            end
        end
    end

    // Phase sequencer; a selection ends wherever chip select rises.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            phase_q <= PH_IDLE;
            cmd_q   <= OPCODE_RESET;
            shift_q <= 24'h000000;
            count_q <= 6'h00;
        end else if (i_clk_en) begin
            if (!cs_low) begin
                phase_q <= PH_IDLE;
                count_q <= 6'h00;
            end else if (cs_fall) begin
                count_q <= 6'h00;
                if (xip_q) begin
                    // Continuous mode: the first bits are the address.
                    cmd_q   <= xip_cmd_q;
                    phase_q <= i_status_register_one[WEL_BIT_INDEX] ? PH_ADDRESS : PH_IGNORE;
                end else begin
                    phase_q <= PH_OPCODE;
                    cmd_q   <= OPCODE_RESET;
                end
            end else if (sample && (phase_q != PH_IDLE) && (phase_q != PH_IGNORE)) begin
                shift_q <= shift_d;
                count_q <= field_done ? 6'h00 : count_d;
                if (field_done) begin
                    case (phase_q)
                        PH_OPCODE: begin
                            cmd_q <= shift_d[7:0];
                            // Unknown opcodes and writes without the latch are ignored to the end.
                            if (is_known(shift_d[7:0]) && i_status_register_one[WEL_BIT_INDEX]) begin
                                phase_q <= PH_ADDRESS;
                            end else begin
                                phase_q <= PH_IGNORE;
                            end
                        end
                        PH_ADDRESS: phase_q <= PH_MODE;
                        PH_MODE:    phase_q <= PH_DATA;
                        default:    phase_q <= phase_q;
                    endcase
                end
            end
        end
    end

    // Byte address: loaded from the address field, stepped after each data byte.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            addr_q <= ADDR_RESET;
        end else if (i_clk_en) begin
            if (field_done && (phase_q == PH_ADDRESS) && cs_low && !cs_fall) begin
                addr_q <= shift_d[19:0];
            end else if (push && cs_low && !cs_fall) begin
                addr_q <= (addr_q == ADDR_TOP) ? ADDR_RESET : addr_q + 20'h00001;
            end
        end
    end

    // Continuous mode is decided by each mode byte and cleared by reset.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            xip_q     <= 1'b0;
            xip_cmd_q <= OPCODE_RESET;
        end else if (i_clk_en) begin
            if (field_done && (phase_q == PH_MODE) && cs_low && !cs_fall) begin
                xip_q     <= mode_match;
                xip_cmd_q <= cmd_q;
            end
        end
    end

    // Rejection flag for the current selection; on the next chip select fall it is set if continuous mode meets a clear latch, else cleared.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_rejected <= 1'b0;
        end else if (i_clk_en) begin
            if (cs_fall) begin
                o_rejected <= xip_q && !i_status_register_one[WEL_BIT_INDEX];
            end else if (cs_low && field_done && (phase_q == PH_OPCODE)) begin
                o_rejected <= !(is_known(shift_d[7:0]) && i_status_register_one[WEL_BIT_INDEX]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry output buffer; head entry drives the outputs directly.
    // The serial host cannot be stalled, so a byte that meets a full buffer is
    // dropped and flagged rather than silently overwriting a held word.
    // The write enable latch is never cleared here, so bursts can follow.

    logic        tail_valid_q;
    logic [19:0] tail_addr_q;
    logic [7:0]  tail_data_q;
    logic        pop;
    logic        accept;

    assign pop    = o_wr_valid && i_wr_ready;
    assign accept = push && cs_low && !cs_fall && !tail_valid_q;

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_wr_valid   <= 1'b0;
            o_wr_addr    <= ADDR_RESET;
            o_wr_data    <= 8'h00;
            tail_valid_q <= 1'b0;
            tail_addr_q  <= ADDR_RESET;
            tail_data_q  <= 8'h00;
        end else if (i_clk_en) begin
            if (!o_wr_valid || pop) begin
                if (tail_valid_q) begin
                    o_wr_valid   <= 1'b1;
                    o_wr_addr    <= tail_addr_q;
                    o_wr_data    <= tail_data_q;
                    tail_valid_q <= accept;
                    tail_addr_q  <= addr_q;
                    tail_data_q  <= shift_d[7:0];
                end else begin
                    o_wr_valid <= accept;
                    o_wr_addr  <= addr_q;
                    o_wr_data  <= shift_d[7:0];
                end
            end else if (accept) begin
                tail_valid_q <= 1'b1;
                tail_addr_q  <= addr_q;
                tail_data_q  <= shift_d[7:0];
            end
        end
    end

    // Sticky overrun for the current selection, and continuous-mode status.
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_overrun           <= 1'b0;
            o_continuous_mode   <= 1'b0;
            o_continuous_opcode <= OPCODE_RESET;
        end else if (i_clk_en) begin
            if (push && cs_low && !cs_fall && tail_valid_q) begin
                o_overrun <= 1'b1;
            end else if (cs_fall) begin
                o_overrun <= 1'b0;
            end
            o_continuous_mode   <= xip_q;
            o_continuous_opcode <= xip_cmd_q;
        end
    end

endmodule // xmw_multi_io_write

// >>> xmw_multi_io_write_asserts.sv
// Concurrent checks on the ports of the multi-line write front end.
`timescale 1ns/1ps
module xmw_multi_io_write_asserts
    import xmw_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_resetn,
    input wire logic        i_clk_en,
    input wire logic        i_cs_n,
    input wire logic        i_sck,
    input wire logic [3:0]  i_io,
    input wire logic [7:0]  i_status_register_one,
    input wire logic        i_wr_ready,
    input wire logic        o_wr_valid,
    input wire logic [19:0] o_wr_addr,
    input wire logic [7:0]  o_wr_data,
    input wire logic        o_continuous_mode,
    input wire logic [7:0]  o_continuous_opcode,
    input wire logic        o_rejected,
    input wire logic        o_overrun
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////////////////////
    // Reset must leave every flag output quiet, the mode opcode zero and continuous mode disarmed.
    a_reset_clears: assert property (disable iff (1'b0) !i_resetn |=>
        !o_wr_valid && !o_continuous_mode && !o_rejected && !o_overrun && o_continuous_opcode == 8'h00)
        else $error("outputs not cleared by reset");
    // An offered write stands unchanged until it is taken, so a held word is never overwritten.
    a_valid_holds: assert property (o_wr_valid && !i_wr_ready |=>
        o_wr_valid && $stable(o_wr_addr) && $stable(o_wr_data)) else $error("offered write changed");
    // Back to back writes of one burst step the address by one, wrapping at the top.
    a_addr_step: assert property (o_wr_valid && i_wr_ready && i_clk_en ##1 o_wr_valid |->
        o_wr_addr == 20'($past(o_wr_addr) + 20'h00001)) else $error("burst address did not step");
    // A new selection clears the dropped-byte flag within the synchroniser delay.
    a_overrun_clear: assert property ($fell(i_cs_n) |-> ##[1:6] !o_overrun) else $error("overrun not cleared");
    // A byte can only be dropped while the buffer holds an offered write.
    a_overrun_full: assert property ($rose(o_overrun) |-> o_wr_valid) else $error("overrun with empty buffer");
    // Continuous mode only ever reuses one of the six write opcodes.
    a_mode_opcode: assert property (o_continuous_mode |-> o_continuous_opcode inside
        {8'hdd, 8'ha2, 8'ha1, 8'h32, 8'hd2, 8'hd1}) else $error("continuous opcode unknown");
    // Only an accepted selection with the latch set may arm continuous mode.
    a_mode_latch: assert property ($rose(o_continuous_mode) |->
        i_status_register_one[WEL_BIT_INDEX] && !o_rejected) else $error("mode armed by ignored selection");
    // An ignored selection never offers a fresh write.
    a_reject_nowrite: assert property (o_rejected |-> !$rose(o_wr_valid)) else $error("write from ignored selection");
    // Refusal is decided while the device is selected.
    a_reject_frame: assert property ($rose(o_rejected) |-> !i_cs_n) else $error("refusal outside selection");
endmodule // xmw_multi_io_write_asserts

bind xmw_multi_io_write xmw_multi_io_write_asserts xmw_multi_io_write_asserts_i (.i_clock(i_clock),
    .i_resetn(i_resetn), .i_clk_en(i_clk_en), .i_cs_n(i_cs_n), .i_sck(i_sck), .i_io(i_io),
    .i_status_register_one(i_status_register_one), .i_wr_ready(i_wr_ready), .o_wr_valid(o_wr_valid),
    .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_continuous_mode(o_continuous_mode),
    .o_continuous_opcode(o_continuous_opcode), .o_rejected(o_rejected), .o_overrun(o_overrun));

// >>> xmw_host_model.sv
// Host serial controller model driving select, serial clock and four data lines.
`timescale 1ns/1ps
module xmw_host_model (
    input  wire logic       i_clock,
    output logic            o_cs_n,
    output logic            o_sck,
    output logic [3:0]      o_io
);
    // Clock idles low outside frames: only clock mode 0 is ever used.
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_io = 4'h5;
    end
    // Each entry is taken by one clock edge; data settles two clocks before it to avoid a race.
    task automatic send(input logic [3:0] q[$]);
        @(negedge i_clock);
        o_cs_n = 1'b0;
        repeat (8) @(negedge i_clock);
        foreach (q[k]) begin
            o_io = q[k];
            repeat (2) @(negedge i_clock);
            o_sck = ~o_sck;
            repeat (2) @(negedge i_clock);
        end
        o_cs_n = 1'b1;
        o_io = ~o_io;
        repeat (8) @(negedge i_clock);
    endtask
endmodule // xmw_host_model

// >>> xmw_multi_io_write_test.sv
// Self-checking bench for the multi-line write front end.
`timescale 1ns/1ps
module xmw_multi_io_write_test;
    import xmw_pkg::*;
    logic        i_clock;
    logic        i_resetn;
    logic        i_ready;
    logic        hold_off;
    logic        cmp_en;
    logic        clk_en;
    logic [7:0]  i_status;
    logic        cs_n;
    logic        sck;
    logic [3:0]  io;
    logic        wr_valid;
    logic [19:0] wr_addr;
    logic [7:0]  wr_data;
    logic        cont_mode;
    logic [7:0]  cont_opc;
    logic        rejected;
    logic        overrun;
    logic [31:0] seed_q = 32'h147a;
    logic [27:0] exp_q[$];
    logic [3:0]  half_q[$];
    int          num_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    logic [7:0]  ops[6] = '{8'hdd, 8'ha2, 8'ha1, 8'h32, 8'hd2, 8'hd1};
    ////////////////////////////////////////////////////////////////////////////
    xmw_multi_io_write xmw_multi_io_write_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_clk_en(clk_en),
        .i_cs_n(cs_n), .i_sck(sck), .i_io(io), .i_status_register_one(i_status), .i_wr_ready(i_ready),
        .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_continuous_mode(cont_mode),
        .o_continuous_opcode(cont_opc), .o_rejected(rejected), .o_overrun(overrun));
    xmw_host_model xmw_host_model_i (.i_clock(i_clock), .o_cs_n(cs_n), .o_sck(sck), .o_io(io));
    // Clock of 40 ns.
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    // Xorshift source with a fixed start, so every run repeats.
    function automatic logic [31:0] rnd();
        seed_q ^= seed_q << 13;
        seed_q ^= seed_q >> 17;
        seed_q ^= seed_q << 5;
        return seed_q;
    endfunction
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Receiver stalls at random so the two-entry buffer really fills.
    always @(negedge i_clock) i_ready <= hold_off ? 1'b0 : 1'(rnd());
    // Every write taken while cmp_en is set must be the next one expected.
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            results();
        end
        if (wr_valid === 1'b1 && i_ready === 1'b1 && clk_en === 1'b1 && cmp_en)
            check("write", exp_q.size() ? exp_q.pop_front() : 28'hfffffff, {wr_addr, wr_data});
    end
    // Lanes used after the opcode: address and mode (data=0) or data bytes (data=1).
    function automatic int lanes(input logic [7:0] op, input bit data);
        case (op)
            OPC_TWO_LINE_DATA_WRITE: return data ? 2 : 1;
            OPC_TWO_LINE_ADDR_DATA_WRITE: return 2;
            OPC_FOUR_LINE_DATA_WRITE: return data ? 4 : 1;
            default: return 4;
        endcase
    endfunction
    // Unused lanes carry noise; single rate gives each value a spare falling edge.
    task automatic push(input logic [7:0] v, input int n, input bit ddr);
        logic [3:0] nib;
        for (int b = 7; b >= 0; b -= n) begin
            nib = 4'(rnd());
            for (int l = 0; l < n; l++) nib[l] = v[b - n + 1 + l];
            half_q.push_back(nib);
            if (!ddr) half_q.push_back(~nib);
        end
    endtask
    task automatic frame(input logic [7:0] op, input bit skip, input logic [19:0] a, input logic [7:0] m,
                         input int nb, input bit wr);
        logic [7:0] d;
        bit         ddr;
        int         n;
        ddr = (op == OPC_DOUBLE_EDGE_WRITE) || (op == OPC_DOUBLE_EDGE_FOUR_LINE_WRITE);
        n = lanes(op, 1'b0);
        if (!skip) push(op, 1, 1'b0);
        push({4'(rnd()), a[19:16]}, n, ddr);
        push(a[15:8], n, ddr);
        push(a[7:0], n, ddr);
        push(m, n, ddr);
        for (int k = 0; k < nb; k++) begin
            d = 8'(rnd());
            push(d, lanes(op, 1'b1), ddr);
            if (wr) exp_q.push_back({20'(a + 20'(k)), d});
        end
        xmw_host_model_i.send(half_q);
        half_q.delete();
        for (int t = 0; t < 400 && exp_q.size() != 0; t++) @(posedge i_clock);
        @(negedge i_clock);
        check("left over", 0, exp_q.size());
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: each command plain, entering and using continuous mode, then refusals.
    initial begin
        logic [7:0] ent;
        logic [7:0] ext;
        bit         ddr;
        i_resetn = 1'b0;
        hold_off = 1'b0;
        cmp_en = 1'b1;
        clk_en = 1'b1;
        i_ready = 1'b0;
        i_status = 8'(rnd()) | 8'h02;
        repeat (12) @(negedge i_clock);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_clock);
        check("mode after reset", 0, {cont_mode, cont_opc, wr_valid, rejected, overrun});
        foreach (ops[i]) begin
            ddr = (ops[i] == OPC_DOUBLE_EDGE_WRITE) || (ops[i] == OPC_DOUBLE_EDGE_FOUR_LINE_WRITE);
            ent = ddr ? MODE_EXACT_ENTRY : {MODE_NIBBLE_ENTRY, 4'(rnd())};
            ext = ddr ? 8'ha4 : {4'h5, 4'(rnd())};
            frame(ops[i], 1'b0, (i == 0) ? 20'hffffe : 20'(rnd()), ext, 3, 1'b1);
            check("mode", 0, cont_mode);
            check("rejected", 0, rejected);
            frame(ops[i], 1'b0, 20'(rnd()), ent, 2, 1'b1);
            check("mode", 32'h1, cont_mode);
            check("mode opcode", ops[i], cont_opc);
            frame(ops[i], 1'b1, 20'(rnd()), ext, 2, 1'b1);
            check("mode", 0, cont_mode);
        end
        i_status = 8'(rnd()) & 8'hfd;
        frame(OPC_FOUR_LINE_ADDR_DATA_WRITE, 1'b0, 20'(rnd()), 8'h00, 2, 1'b0);
        check("rejected", 32'h1, rejected);
        i_status = 8'h02;
        frame(8'h55, 1'b0, 20'(rnd()), 8'h00, 2, 1'b0);
        check("rejected", 32'h1, rejected);
        frame(OPC_TWO_LINE_ADDR_DATA_WRITE, 1'b0, 20'(rnd()), 8'ha0, 1, 1'b1);
        i_resetn = 1'b0;
        repeat (4) @(negedge i_clock);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_clock);
        check("mode after reset", 0, cont_mode);
        frame(OPC_TWO_LINE_ADDR_DATA_WRITE, 1'b0, 20'(rnd()), 8'h00, 1, 1'b1);
        hold_off = 1'b1;
        cmp_en = 1'b0;
        frame(OPC_FOUR_LINE_ADDR_DATA_WRITE, 1'b0, 20'(rnd()), 8'h00, 5, 1'b0);
        check("overrun", 32'h1, overrun);
        // A low clock enable must keep the offered write standing although the receiver is again ready at random.
        clk_en = 1'b0;
        hold_off = 1'b0;
        repeat (10) @(negedge i_clock);
        check("frozen write", 32'h1, wr_valid);
        check("frozen overrun", 32'h1, overrun);
        clk_en = 1'b1;
        repeat (20) @(negedge i_clock);
        cmp_en = 1'b1;
        frame(OPC_FOUR_LINE_DATA_WRITE, 1'b0, 20'(rnd()), 8'h00, 2, 1'b1);
        check("overrun", 0, overrun);
        results();
    end
endmodule // xmw_multi_io_write_test
